// *** lcm_consts.svh ***
`ifndef LCM_CONSTS_SVH
`define LCM_CONSTS_SVH
// Bit positions of the link control register.
`define LCM_BIT_ISO_FILTER   12
`define LCM_BIT_CS_ENABLE    11
`define LCM_BIT_EXT_SELECT   10
`define LCM_BIT_OFFSET_RUN   9
`define LCM_BIT_TX_IDLE      6
`define LCM_BIT_ROOT         5
`define LCM_BIT_BUSY_PHASE   4
`define LCM_ACK_LSB          28
`define LCM_ACK_MSB          31
// Reset values.
`define LCM_CTRL_RESET       32'h0000_0000
`define LCM_ACK_RESET        4'h0
// Cycle timer layout: seconds 31:25, count 24:12, offset 11:0.
`define LCM_OFFSET_LSB       0
`define LCM_OFFSET_MSB       11
`define LCM_COUNT_LSB        12
`define LCM_COUNT_MSB        24
`define LCM_SECONDS_LSB      25
`define LCM_SECONDS_MSB      31
`define LCM_OFFSET_WRAP      12'hBFF
`define LCM_COUNT_WRAP       13'h1F3F
// Register selects on the host port.
`define LCM_SEL_CONTROL      1'b0
`define LCM_SEL_CYCLE_TIME   1'b1
`endif

// *** lcm_core_model.sv ***
`timescale 1ns/1ns
// Link core stand-in; the bench steers it through its tasks.
module lcm_core_model (
  input  wire logic            clk_sys,
  input  wire logic            iso_packet_accept,
  output lcm_pkg::lcm_status_t core_status,
  output logic                 self_id_done,
  output logic                 iso_packet_valid,
  output logic                 iso_in_window,
  output logic                 cycle_timeout_flag,
  output logic                 external_cycle_input
);
  // No queued traffic, so a reset never cuts a transfer.
  initial begin
    core_status = '0;
    self_id_done = 1'b0;
    iso_packet_valid = 1'b0;
    iso_in_window = 1'b0;
    cycle_timeout_flag = 1'b0;
    external_cycle_input = 1'b0;
  end
  task automatic status(input logic idle, input logic busy_b);
    @(negedge clk_sys);
    core_status.tx_idle = idle;
    core_status.busy_b_next = busy_b;
  endtask
  // The code is only good with its strobe; it turns to garbage after.
  task automatic ack(input logic [3:0] c);
    @(negedge clk_sys);
    core_status.ack_code = c;
    core_status.ack_valid = 1'b1;
    @(negedge clk_sys);
    core_status.ack_valid = 1'b0;
    core_status.ack_code = ~c;
  endtask
  task automatic self_id(input logic root);
    @(negedge clk_sys);
    core_status.is_root = root;
    self_id_done = 1'b1;
    @(negedge clk_sys);
    self_id_done = 1'b0;
  endtask
  task automatic timeout;
    @(negedge clk_sys);
    cycle_timeout_flag = 1'b1;
    @(negedge clk_sys);
    cycle_timeout_flag = 1'b0;
  endtask
  task automatic cycle_edge;
    @(negedge clk_sys);
    external_cycle_input = 1'b1;
    repeat (4) @(negedge clk_sys);
    external_cycle_input = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  // Reports whether the packet was taken one cycle after its strobe.
  task automatic send_iso(input logic win, output logic acc);
    @(negedge clk_sys);
    iso_in_window = win;
    iso_packet_valid = 1'b1;
    @(negedge clk_sys);
    iso_packet_valid = 1'b0;
    iso_in_window = ~win;
    acc = iso_packet_accept;
  endtask
endmodule

// *** lcm_cycle_timer.sv ***
`timescale 1ns/1ns
`include "lcm_consts.svh"
// Cycle timer: offset, count and seconds fields.
module lcm_cycle_timer (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic        ext_select,
  input  wire logic        ext_edge,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  output logic      [31:0] value,
  output logic             count_step
);
  logic [31:0] value_nxt;
  logic        step_nxt;
  logic [11:0] offs;
  logic [12:0] cnt;
  logic [6:0]  secs;

  assign offs = value[`LCM_OFFSET_MSB:`LCM_OFFSET_LSB];
  assign cnt  = value[`LCM_COUNT_MSB:`LCM_COUNT_LSB];
  assign secs = value[`LCM_SECONDS_MSB:`LCM_SECONDS_LSB];

  // Host writes win; when the timer is stopped it is a plain scratch register.
  always_comb begin
    value_nxt = value;
    step_nxt  = 1'b0;
    if (wr_en) begin
      value_nxt = wr_data;
    end else if (run) begin
      if (ext_select) begin
        if (ext_edge) begin
          step_nxt  = 1'b1;
          value_nxt[`LCM_OFFSET_MSB:`LCM_OFFSET_LSB] = 12'h000;
        end else if (offs != `LCM_OFFSET_WRAP) begin
          value_nxt[`LCM_OFFSET_MSB:`LCM_OFFSET_LSB] = offs + 12'h001;
        end
      end else if (offs == `LCM_OFFSET_WRAP) begin
        step_nxt  = 1'b1;
        value_nxt[`LCM_OFFSET_MSB:`LCM_OFFSET_LSB] = 12'h000;
      end else begin
        value_nxt[`LCM_OFFSET_MSB:`LCM_OFFSET_LSB] = offs + 12'h001;
      end
      if (step_nxt) begin
        if (cnt == `LCM_COUNT_WRAP) begin
          value_nxt[`LCM_COUNT_MSB:`LCM_COUNT_LSB]     = 13'h0000;
          value_nxt[`LCM_SECONDS_MSB:`LCM_SECONDS_LSB] = secs + 7'h01;
        end else begin
          value_nxt[`LCM_COUNT_MSB:`LCM_COUNT_LSB] = cnt + 13'h0001;
        end
      end
    end
  end

  // Timer state.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      value      <= 32'h0000_0000;
      count_step <= 1'b0;
    end else begin
      value      <= value_nxt;
      count_step <= step_nxt;
    end
  end
endmodule

// *** lcm_link_control.sv ***
`timescale 1ns/1ns
`include "lcm_consts.svh"
// Function
// - Filter bit set drops iso packets outside cycle start to subaction gap.
// - Enabled master, root and count step send a cycle-start packet.
// - A cycle timeout stops the cycle master function.
// - After timeout, mastering resumes only after enable cleared then set.
// - External select: each input rising edge steps count and clears offset while the run bit is set.
// - Internal select: count steps only when offset wraps.
// - Offset runs while its run bit is set, holds otherwise; under external select the code stops it at 0xBFF until the next input edge.
// - Stopped cycle timer behaves as plain host read/write register.
// - Transmitter idle bit reads one when transmitter can accept work.
// - Root bit shows root status, refreshed when self-ID ends.
// - Busy phase bit: zero busy A, one busy B next.
// - Ack field holds last ack for async transmit FIFO packets.
module lcm_link_control (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                host_wr,
  input  wire logic                host_rd,
  input  wire logic                host_sel,
  input  wire logic [31:0]         host_wdata,
  output logic      [31:0]         host_rdata,
  input  wire logic                external_cycle_input,
  input  wire logic                cycle_timeout_flag,
  input  wire logic                self_id_done,
  input  wire logic                iso_packet_valid,
  input  wire logic                iso_in_window,
  input  wire lcm_pkg::lcm_status_t core_status,
  output lcm_pkg::lcm_ctrl_t       ctrl_out,
  output logic                     iso_packet_accept,
  output logic      [31:0]         cycle_time_value
);
  logic        rst_meta_r;
  logic        rst_n_r;
  logic        cyc_in_meta_r;
  logic        cyc_in_sync_r;
  logic        cyc_in_prev_r;
  logic        iso_window_filter_r;
  logic        cycle_start_sender_enable_r;
  logic        external_cycle_select_r;
  logic        cycle_offset_run_r;
  logic        master_halted_r;
  logic        is_root_r;
  logic        transmitter_idle_r;
  logic        busy_phase_select_r;
  logic [3:0]  last_async_tx_ack_r;
  logic [31:0] timer_value;
  logic        count_step;
  logic        ext_edge;
  logic        ctrl_wr;
  logic        timer_wr;

  // Decodes a host write strobe for one register select.
  function automatic logic wr_hit(input logic wr, input logic sel, input logic want);
    wr_hit = wr && (sel == want);
  endfunction

  assign ctrl_wr  = wr_hit(host_wr, host_sel, `LCM_SEL_CONTROL);
  assign timer_wr = wr_hit(host_wr, host_sel, `LCM_SEL_CYCLE_TIME) && !cycle_offset_run_r;
  assign ext_edge = cyc_in_sync_r && !cyc_in_prev_r;

  // Reset release through two flops so every flop leaves reset on the same edge.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // The cycle input is a pin, so it is synchronised before the edge detector.
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cyc_in_meta_r <= 1'b0;
      cyc_in_sync_r <= 1'b0;
      cyc_in_prev_r <= 1'b0;
    end else begin
      cyc_in_meta_r <= external_cycle_input;
      cyc_in_sync_r <= cyc_in_meta_r;
      cyc_in_prev_r <= cyc_in_sync_r;
    end
  end

  // Writable control bits; read-only positions in the write data are dropped.
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      iso_window_filter_r         <= 1'b0;
      cycle_start_sender_enable_r <= 1'b0;
      external_cycle_select_r     <= 1'b0;
      cycle_offset_run_r          <= 1'b0;
    end else if (ctrl_wr) begin
      iso_window_filter_r         <= host_wdata[`LCM_BIT_ISO_FILTER];
      cycle_start_sender_enable_r <= host_wdata[`LCM_BIT_CS_ENABLE];
      external_cycle_select_r     <= host_wdata[`LCM_BIT_EXT_SELECT];
      cycle_offset_run_r          <= host_wdata[`LCM_BIT_OFFSET_RUN];
    end
  end

  // A timeout latches a halt; only a write of zero to the enable releases it,
  // so a later write of one restarts mastering. Timeout wins over release.
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      master_halted_r <= 1'b0;
    end else if (cycle_timeout_flag && cycle_start_sender_enable_r) begin
      master_halted_r <= 1'b1;
    end else if (ctrl_wr && !host_wdata[`LCM_BIT_CS_ENABLE]) begin
      master_halted_r <= 1'b0;
    end
  end

  // Root status is sampled only when self-identification ends.
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      is_root_r <= 1'b0;
    end else if (self_id_done) begin
      is_root_r <= core_status.is_root;
    end
  end

  // Live status from the link core, registered once.
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      transmitter_idle_r  <= 1'b0;
      busy_phase_select_r <= 1'b0;
    end else begin
      transmitter_idle_r  <= core_status.tx_idle;
      busy_phase_select_r <= core_status.busy_b_next;
    end
  end

  // Last acknowledge for async transmit FIFO packets, held until the next one.
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      last_async_tx_ack_r <= `LCM_ACK_RESET;
    end else if (core_status.ack_valid) begin
      last_async_tx_ack_r <= core_status.ack_code;
    end
  end

  lcm_cycle_timer u_timer (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n_r),
    .run        (cycle_offset_run_r),
    .ext_select (external_cycle_select_r),
    .ext_edge   (ext_edge),
    .wr_en      (timer_wr),
    .wr_data    (host_wdata),
    .value      (timer_value),
    .count_step (count_step)
  );

  // Cycle-start request and iso acceptance to the link core.
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_out          <= '0;
      iso_packet_accept <= 1'b0;
      cycle_time_value  <= 32'h0000_0000;
    end else begin
      ctrl_out.iso_window_filter   <= iso_window_filter_r;
      ctrl_out.cycle_start_request <= count_step && cycle_start_sender_enable_r
                                      && is_root_r && !master_halted_r
                                      && !cycle_timeout_flag;
      iso_packet_accept <= iso_packet_valid
                           && (!iso_window_filter_r || iso_in_window);
      cycle_time_value  <= timer_value;
    end
  end

  // Read data, registered one cycle after the read strobe.
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      host_rdata <= `LCM_CTRL_RESET;
    end else if (host_rd) begin
      if (host_sel == `LCM_SEL_CYCLE_TIME) begin
        host_rdata <= timer_value;
      end else begin
        host_rdata <= `LCM_CTRL_RESET;
        host_rdata[`LCM_ACK_MSB:`LCM_ACK_LSB] <= last_async_tx_ack_r;
        host_rdata[`LCM_BIT_ISO_FILTER]       <= iso_window_filter_r;
        host_rdata[`LCM_BIT_CS_ENABLE]        <= cycle_start_sender_enable_r;
        host_rdata[`LCM_BIT_EXT_SELECT]       <= external_cycle_select_r;
        host_rdata[`LCM_BIT_OFFSET_RUN]       <= cycle_offset_run_r;
        host_rdata[`LCM_BIT_TX_IDLE]          <= transmitter_idle_r;
        host_rdata[`LCM_BIT_ROOT]             <= is_root_r;
        host_rdata[`LCM_BIT_BUSY_PHASE]       <= busy_phase_select_r;
      end
    end
  end
endmodule

// *** lcm_link_control_props.sv ***
`timescale 1ns/1ns
// Port checks, fed by shadow copies of the control state.
module lcm_link_control_props (
  input wire logic                 clk_sys,
  input wire logic                 rst_b,
  input wire logic                 host_wr,
  input wire logic                 host_rd,
  input wire logic                 host_sel,
  input wire logic [31:0]          host_wdata,
  input wire logic [31:0]          host_rdata,
  input wire logic                 external_cycle_input,
  input wire logic                 cycle_timeout_flag,
  input wire logic                 self_id_done,
  input wire logic                 iso_packet_valid,
  input wire logic                 iso_in_window,
  input wire lcm_pkg::lcm_status_t core_status,
  input wire lcm_pkg::lcm_ctrl_t   ctrl_out,
  input wire logic                 iso_packet_accept,
  input wire logic [31:0]          cycle_time_value
);
  logic [3:0]  ctl_r;
  logic        root_r;
  logic        halt_r;
  logic [3:0]  ack_r;
  logic [1:0]  quiet_r;
  logic        run_ok;
  logic        start_ok;
  logic [11:0] off;
  // Shadows of bits 12..9 and of the reported status.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= 4'h0;
      root_r <= 1'b0;
      ack_r <= 4'h0;
    end else begin
      if (host_wr && !host_sel) ctl_r <= host_wdata[12:9];
      if (self_id_done) root_r <= core_status.is_root;
      if (core_status.ack_valid) ack_r <= core_status.ack_code;
    end
  end
  // A timeout wins over the clearing write.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) halt_r <= 1'b0;
    else if (cycle_timeout_flag && ctl_r[2]) halt_r <= 1'b1;
    else if (host_wr && !host_sel && !host_wdata[11]) halt_r <= 1'b0;
  end
  // Timer checks wait until the write pipeline has drained.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) quiet_r <= 2'h0;
    else if (host_wr) quiet_r <= 2'h0;
    else if (quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
  end
  assign run_ok = quiet_r == 2'h3 && ctl_r[0] && !ctl_r[1];
  assign start_ok = ctl_r[2] && root_r && !halt_r && !cycle_timeout_flag;
  assign off = cycle_time_value[11:0];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  sequence s_ctl_rd;
    host_rd && !host_sel;
  endsequence
  sequence s_tim_wr;
    host_wr && host_sel && !ctl_r[0] ##1 1'b1;
  endsequence
  a_ctl_bits: assert property (s_ctl_rd |=> host_rdata[12:9] == $past(ctl_r))
    else $error("control bits wrong");
  a_root_bit: assert property (s_ctl_rd |=> host_rdata[5] == $past(root_r))
    else $error("root bit wrong");
  a_ack_field: assert property (s_ctl_rd |=> host_rdata[31:28] == $past(ack_r))
    else $error("ack field wrong");
  a_timer_read: assert property (host_rd && host_sel |=> host_rdata == cycle_time_value)
    else $error("timer read wrong");
  a_timer_write: assert property (s_tim_wr |=> cycle_time_value == $past(host_wdata, 2))
    else $error("timer write lost");
  a_offset_hold: assert property (quiet_r == 2'h3 && ctl_r == 4'h0 |-> $stable(off))
    else $error("offset moved");
  a_offset_step: assert property (run_ok |-> off == ($past(off) == 12'hBFF ? 12'h0 : $past(off) + 12'h1))
    else $error("offset step wrong");
  a_count_hold: assert property (run_ok && off[11:1] != 11'h0 |-> $stable(cycle_time_value[24:12]))
    else $error("count moved");
  a_iso_gate: assert property (iso_packet_valid && ctl_r[3] == ctrl_out.iso_window_filter |=>
    iso_packet_accept == ($past(iso_in_window) || !$past(ctl_r[3])))
    else $error("iso gate wrong");
  a_start_gate: assert property (ctrl_out.cycle_start_request |-> $past(start_ok))
    else $error("stray cycle start");
endmodule

// *** lcm_link_control_tb.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value at %0t got %h", $time, a); end end
// Host tasks on the register port; the core model sits on the far side.
module lcm_link_control_tb;
  logic                 clk_sys = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 host_wr = 1'b0;
  logic                 host_rd = 1'b0;
  logic                 host_sel = 1'b0;
  logic [31:0]          host_wdata = 32'h0;
  logic [31:0]          host_rdata, cycle_time_value, d, e;
  logic                 external_cycle_input, cycle_timeout_flag, self_id_done, a;
  logic                 iso_packet_valid, iso_in_window, iso_packet_accept;
  lcm_pkg::lcm_status_t core_status;
  lcm_pkg::lcm_ctrl_t   ctrl_out;
  int                   bad_count = 0, total_checks = 0, starts = 0, n;
  lcm_link_control u_lcm_link_control (.*);
  lcm_core_model   u_lcm_core_model (.*);
  always #25 clk_sys = ~clk_sys;
  // Each cycle-start pulse lasts one cycle.
  always @(posedge clk_sys) if (ctrl_out.cycle_start_request === 1'b1) starts++;
  task automatic wr(input logic s, input logic [31:0] v);
    @(negedge clk_sys);
    host_wr = 1'b1;
    host_sel = s;
    host_wdata = v;
    @(negedge clk_sys);
    host_wr = 1'b0;
  endtask
  task automatic rd(input logic s, output logic [31:0] v);
    @(negedge clk_sys);
    host_rd = 1'b1;
    host_sel = s;
    @(negedge clk_sys);
    host_rd = 1'b0;
    v = host_rdata;
  endtask
  // One offset wrap under control value c; n gets the starts seen.
  task automatic arm(input logic [31:0] c);
    wr(1'b0, c & ~32'h0000_0200);
    wr(1'b1, 32'h0000_0BF0);
    n = starts;
    wr(1'b0, c);
    repeat (25) @(negedge clk_sys);
    n = starts - n;
  endtask
  task automatic t_ctrl;
    wr(1'b0, 32'hF000_1C70);
    rd(1'b0, d);
    `CHK(d, 32'h0000_1C00)
    wr(1'b0, 32'h0);
    wr(1'b1, 32'h1234_5678);
    repeat (5) @(negedge clk_sys);
    rd(1'b1, d);
    `CHK(d, 32'h1234_5678)
    $display("t_ctrl done");
  endtask
  task automatic t_run;
    wr(1'b1, 32'h0000_0BF0);
    wr(1'b0, 32'h0000_0200);
    repeat (20) @(negedge clk_sys);
    wr(1'b1, 32'h0);
    rd(1'b1, d);
    `CHK(d[24:12], 13'h1)
    wr(1'b0, 32'h0);
    rd(1'b1, d);
    repeat (4) @(negedge clk_sys);
    rd(1'b1, e);
    `CHK(e, d)
    $display("t_run done");
  endtask
  task automatic t_master;
    u_lcm_core_model.self_id(1'b1);
    rd(1'b0, d);
    `CHK(d[5], 1'b1)
    arm(32'h0000_0A00);
    `CHK(n, 1)
    u_lcm_core_model.timeout();
    arm(32'h0000_0A00);
    `CHK(n, 0)
    wr(1'b0, 32'h0);
    arm(32'h0000_0A00);
    `CHK(n, 1)
    wr(1'b0, 32'h0);
    $display("t_master done");
  endtask
  task automatic t_ext;
    // The timer only takes a host write while stopped, so load it first, then run.
    wr(1'b0, 32'h0000_0400);
    wr(1'b1, 32'h0000_0005);
    wr(1'b0, 32'h0000_0600);
    u_lcm_core_model.cycle_edge();
    u_lcm_core_model.cycle_edge();
    rd(1'b1, d);
    `CHK(d[24:12], 13'h0002)
    `CHK(d[11:4], 8'h00)
    wr(1'b0, 32'h0);
    $display("t_ext done");
  endtask
  task automatic t_iso;
    u_lcm_core_model.send_iso(1'b0, a);
    `CHK(a, 1'b1)
    wr(1'b0, 32'h0000_1000);
    u_lcm_core_model.send_iso(1'b0, a);
    `CHK(a, 1'b0)
    u_lcm_core_model.send_iso(1'b1, a);
    `CHK(a, 1'b1)
    u_lcm_core_model.status(1'b1, 1'b1);
    u_lcm_core_model.ack(4'hA);
    rd(1'b0, d);
    `CHK({d[31:28], d[6], d[4]}, 6'h2B)
    $display("t_iso done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_ctrl;
    t_run;
    t_master;
    t_ext;
    t_iso;
    test_done;
  end
  // The scenarios need well under a tenth of this span.
  initial begin
    #2000000;
    bad_count++;
    test_done;
  end
endmodule
bind lcm_link_control lcm_link_control_props u_lcm_link_control_props (.*);

// *** lcm_pkg.sv ***
package lcm_pkg;
  // Status inputs reported by the link core.
  typedef struct packed {
    logic       tx_idle;
    logic       is_root;
    logic       busy_b_next;
    logic       ack_valid;
    logic [3:0] ack_code;
  } lcm_status_t;
  // Controls driven to the link core.
  typedef struct packed {
    logic iso_window_filter;
    logic cycle_start_request;
  } lcm_ctrl_t;
endpackage
